// ===== verilog/rtport_pkg.sv
// constants for the real-time output port block
package rtport_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [3:0] OFF_NIB_BUF  = 4'h0;
    localparam logic [3:0] OFF_NIB_CTRL = 4'h1;
    localparam logic [3:0] OFF_VID_BUF  = 4'h2;
    localparam logic [3:0] OFF_VID_MODE = 4'h3;
    localparam logic [3:0] OFF_HEAD_AMP = 4'h4;
    localparam logic [3:0] OFF_P0_DIR   = 4'h5;
    localparam logic [3:0] OFF_P0_LAT   = 4'h6;
    localparam logic [3:0] OFF_P8_DIR   = 4'h7;
    localparam logic [3:0] OFF_P8_LAT   = 4'h8;
    localparam logic [3:0] OFF_P0_PINS  = 4'h9;
    localparam logic [3:0] OFF_P8_PINS  = 4'ha;
    localparam logic [3:0] OFF_P2_PINS  = 4'hb;
    localparam logic [3:0] OFF_P7_PINS  = 4'hc;
    localparam logic [3:0] OFF_HEAD_LAT = 4'hd;
    // nibble port control fields
    localparam int NC_MODE8  = 0;
    localparam int NC_LO_EXT = 1;
    localparam int NC_RT_HI  = 2;
    localparam int NC_RT_LO  = 3;
    // video port mode fields
    localparam int VM_RT0    = 0;
    localparam int VM_RT2    = 2;
    localparam int VM_RT3    = 3;
    localparam int VM_SRC_LO = 4;
    localparam int VM_SUPER  = 6;
    localparam int VM_PSV    = 7;
    // reset values
    localparam logic [7:0] RST_REG8   = 8'h00;
    localparam logic [1:0] RST_REG2   = 2'h0;
    localparam logic [3:0] PORT2_PU   = 4'hc;
    // pseudo vsync pattern, one step per hsync rising edge
    localparam logic [7:0] PSV_PATTERN = 8'h3c;
    // pseudo-sync bit levels
    localparam logic [1:0] LVL_LOW  = 2'h0;
    localparam logic [1:0] LVL_HIGH = 2'h1;
    localparam logic [1:0] LVL_HIZ  = 2'h2;
    // bit 0 trigger sources
    localparam logic [1:0] SRC_T0C1 = 2'h0;
    localparam logic [1:0] SRC_T0C2 = 2'h1;
    localparam logic [1:0] SRC_T1C3 = 2'h2;
    localparam logic [1:0] SRC_T5C0 = 2'h3;
    typedef enum logic [0:0] {
        PSV_IDLE = 1'b0,
        PSV_RUN  = 1'b1
    } psv_state_t;
endpackage

// ===== verilog/match_pulse.sv
// coincidence pulse between a timer count and a compare value
`timescale 1ns/1ps
module match_pulse #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_b,
    // timer side
    input  wire logic [W-1:0] count,
    input  wire logic [W-1:0] cmp,
    // one-cycle match
    output logic              match_q
);
    initial begin
        if (W < 1) $error("match_pulse: width must be positive");
    end

    wire eq = (count == cmp);
    logic eq_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            eq_q    <= 1'b0;
            match_q <= 1'b0;
        end else begin
            eq_q    <= eq;
            match_q <= eq & ~eq_q;
        end
    end

    a_match_rise: assert property (
        @(posedge mclk) disable iff (!rst_b)
        eq && !$past(eq) |=> match_q)
        else $error("coincidence did not raise match");
endmodule

// ===== verilog/realtime_output_port.sv
// real-time output ports, general port pins and register slave
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module realtime_output_port
    import rtport_pkg::*;
#(
    parameter int TW = 16
) (
    // clock and reset
    input  wire logic                         mclk,
    input  wire logic                         rst_b,
    // register port
    input  wire logic [rtport_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [rtport_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [rtport_pkg::DATA_W-1:0] reg_rdata,
    // timer zero count and compares
    input  wire logic [TW-1:0]                timer_zero_count,
    input  wire logic [TW-1:0]                timer_zero_cmp0,
    input  wire logic [TW-1:0]                timer_zero_cmp1,
    input  wire logic [TW-1:0]                timer_zero_cmp2,
    // other trigger events and sync
    input  wire logic                         timer1_cmp3_match,
    input  wire logic                         timer5_cmp0_match,
    input  wire logic                         ext_irq0_event,
    input  wire logic                         hsync,
    // nibble port pins
    input  wire logic [7:0]                   p0_in,
    output logic      [7:0]                   p0_out,
    output logic      [7:0]                   p0_oe_b,
    output logic      [7:0]                   p0_pu,
    // video port pins
    input  wire logic [7:0]                   p8_in,
    output logic      [7:0]                   p8_out,
    output logic      [7:0]                   p8_oe_b,
    output logic      [7:0]                   p8_pu,
    // input-only ports
    input  wire logic [3:0]                   p2_in,
    output logic      [3:0]                   p2_pu,
    input  wire logic [7:0]                   p7_in
);
    import rtport_pkg::*;

    initial begin
        if (TW < 1) $error("realtime_output_port: TW must be positive");
    end

    ////////////////////////////////////////////////////////////////////
    // trigger sources
    logic timer0_cmp0_match;
    logic timer0_cmp1_match;
    logic timer0_cmp2_match;

    match_pulse #(.W(TW)) u_cmp0 (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .count   (timer_zero_count),
        .cmp     (timer_zero_cmp0),
        .match_q (timer0_cmp0_match)
    );
    match_pulse #(.W(TW)) u_cmp1 (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .count   (timer_zero_count),
        .cmp     (timer_zero_cmp1),
        .match_q (timer0_cmp1_match)
    );
    match_pulse #(.W(TW)) u_cmp2 (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .count   (timer_zero_count),
        .cmp     (timer_zero_cmp2),
        .match_q (timer0_cmp2_match)
    );

    ////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] nib_buf_q;
    logic [7:0] nib_ctrl_q;
    logic [1:0] vid_buf_q;
    logic [7:0] port_mode_ctrl_video_q;
    logic [1:0] head_amp_output_ctrl_q;
    logic [7:0] p0_dir_q;
    logic [7:0] p0_lat_q;
    logic [7:0] p8_dir_q;
    logic [7:0] p8_gen_q;
    logic [1:0] head_lat_q;
    logic [1:0] psv_lvl_q;
    logic [2:0] psv_step_q;
    logic       hs_q;
    psv_state_t psv_state_q;

    wire wr_nbuf  = reg_wr && (reg_addr == OFF_NIB_BUF);
    wire wr_nctl  = reg_wr && (reg_addr == OFF_NIB_CTRL);
    wire wr_vbuf  = reg_wr && (reg_addr == OFF_VID_BUF);
    wire wr_vmode = reg_wr && (reg_addr == OFF_VID_MODE);
    wire wr_head_amp_output_ctrl  = reg_wr && (reg_addr == OFF_HEAD_AMP);
    wire wr_p0dir = reg_wr && (reg_addr == OFF_P0_DIR);
    wire wr_p0lat = reg_wr && (reg_addr == OFF_P0_LAT);
    wire wr_p8dir = reg_wr && (reg_addr == OFF_P8_DIR);
    wire wr_p8lat = reg_wr && (reg_addr == OFF_P8_LAT);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            nib_buf_q              <= RST_REG8;
            nib_ctrl_q             <= RST_REG8;
            vid_buf_q              <= RST_REG2;
            port_mode_ctrl_video_q <= RST_REG8;
            head_amp_output_ctrl_q <= RST_REG2;
            p0_dir_q               <= RST_REG8;
            p8_dir_q               <= RST_REG8;
            p8_gen_q               <= RST_REG8;
        end else begin
            if (wr_nbuf)  nib_buf_q              <= reg_wdata;
            if (wr_nctl)  nib_ctrl_q             <= reg_wdata;
            if (wr_vbuf)  vid_buf_q              <= reg_wdata[1:0];
            if (wr_vmode) port_mode_ctrl_video_q <= reg_wdata;
            if (wr_head_amp_output_ctrl)  head_amp_output_ctrl_q <= reg_wdata[1:0];
            if (wr_p0dir) p0_dir_q               <= reg_wdata;
            if (wr_p8dir) p8_dir_q               <= reg_wdata;
            if (wr_p8lat) p8_gen_q               <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // nibble real-time port
    wire mode8  = nib_ctrl_q[NC_MODE8];
    wire rt_hi  = nib_ctrl_q[NC_RT_HI];
    wire rt_lo  = nib_ctrl_q[NC_RT_LO];
    wire trig_lo = nib_ctrl_q[NC_LO_EXT] ? ext_irq0_event
                                         : timer0_cmp2_match;
    wire trig_hi = mode8 ? trig_lo : timer0_cmp1_match;
    wire load_hi = rt_hi && trig_hi;
    wire load_lo = rt_lo && trig_lo;
    wire [7:0] p0_rt_mask = {{4{rt_hi}}, {4{rt_lo}}};

    // software writes only reach nibbles not in real-time use
    wire [3:0] p0_hi_d = load_hi ? nib_buf_q[7:4] :
                         (wr_p0lat && !rt_hi) ? reg_wdata[7:4] :
                         p0_lat_q[7:4];
    wire [3:0] p0_lo_d = load_lo ? nib_buf_q[3:0] :
                         (wr_p0lat && !rt_lo) ? reg_wdata[3:0] :
                         p0_lat_q[3:0];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            p0_lat_q <= RST_REG8;
        end else begin
            p0_lat_q <= {p0_hi_d, p0_lo_d};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // video real-time port
    wire       rt0    = port_mode_ctrl_video_q[VM_RT0];
    wire       rt2    = port_mode_ctrl_video_q[VM_RT2];
    wire       rt3    = port_mode_ctrl_video_q[VM_RT3];
    wire       psv_on = port_mode_ctrl_video_q[VM_PSV];
    wire       sup_on = port_mode_ctrl_video_q[VM_SUPER];
    wire [1:0] src0   = port_mode_ctrl_video_q[VM_SRC_LO +: 2];
    wire [7:0] p8_rt_mask = {4'h0, rt3, rt2, 1'b0, rt0};

    wire bit0_trig = (src0 == SRC_T0C1) ? timer0_cmp1_match :
                     (src0 == SRC_T0C2) ? timer0_cmp2_match :
                     (src0 == SRC_T1C3) ? timer1_cmp3_match :
                                          timer5_cmp0_match;
    wire bit0_load = rt0 && bit0_trig;
    wire hs_rise   = hsync && !hs_q;
    wire psv_run   = (psv_state_q == PSV_RUN);

    wire [1:0] head_lat_d = wr_head_amp_output_ctrl ? reg_wdata[1:0] :
                            timer0_cmp0_match ? head_amp_output_ctrl_q :
                            head_lat_q;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            head_lat_q <= RST_REG2;
            psv_lvl_q  <= LVL_LOW;
            hs_q       <= 1'b0;
        end else begin
            head_lat_q <= head_lat_d;
            hs_q       <= hsync;
            if (bit0_load && !psv_on) begin
                psv_lvl_q <= vid_buf_q;
            end
        end
    end

    // pattern sequencer, repeats until mode or pin leaves real-time use
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            psv_state_q <= PSV_IDLE;
            psv_step_q  <= 3'h0;
        end else begin
            case (psv_state_q)
                PSV_IDLE: begin
                    if (bit0_load && psv_on) begin
                        psv_state_q <= PSV_RUN;
                        psv_step_q  <= 3'h0;
                    end
                end
                PSV_RUN: begin
                    if (!psv_on || !rt0) begin
                        psv_state_q <= PSV_IDLE;
                    end else if (bit0_load) begin
                        psv_step_q  <= 3'h0;
                    end else if (hs_rise) begin
                        psv_step_q  <= psv_step_q + 3'h1;
                    end
                end
                default: psv_state_q <= PSV_IDLE;
            endcase
        end
    end

    wire [1:0] bit0_lvl = psv_run ? {1'b0, PSV_PATTERN[psv_step_q]}
                                  : psv_lvl_q;
    // hsync pulls a high level low while it lasts
    wire       bit0_val = (bit0_lvl == LVL_HIGH) && !(sup_on && hsync);
    wire       bit0_hiz = (bit0_lvl == LVL_HIZ);

    ////////////////////////////////////////////////////////////////////
    // pin stage
    wire [7:0] p8_rt_val = {4'h0, head_lat_q[1], head_lat_q[0],
                            1'b0, bit0_val};
    wire [7:0] p8_out_d = (p8_gen_q & ~p8_rt_mask) |
                          (p8_rt_val & p8_rt_mask);
    wire [7:0] p8_drive = (p8_dir_q & ~p8_rt_mask) |
                          (p8_rt_mask & {7'h7f, !bit0_hiz});
    wire [7:0] p0_drive = p0_dir_q | p0_rt_mask;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            p0_out  <= RST_REG8;
            p0_oe_b <= 8'hff;
            p0_pu   <= 8'hff;
            p8_out  <= RST_REG8;
            p8_oe_b <= 8'hff;
            p8_pu   <= 8'hff;
            p2_pu   <= PORT2_PU;
        end else begin
            p0_out  <= p0_lat_q;
            p0_oe_b <= ~p0_drive;
            p0_pu   <= ~p0_drive;
            p8_out  <= p8_out_d;
            p8_oe_b <= ~p8_drive;
            p8_pu   <= ~p8_drive;
            p2_pu   <= PORT2_PU;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path, data one cycle after the strobe
    // port 7 is plain input, no pull-up control at all
    wire [7:0] rd_mux =
        (reg_addr == OFF_NIB_BUF)  ? nib_buf_q :
        (reg_addr == OFF_NIB_CTRL) ? nib_ctrl_q :
        (reg_addr == OFF_VID_BUF)  ? {6'h00, vid_buf_q} :
        (reg_addr == OFF_VID_MODE) ? port_mode_ctrl_video_q :
        (reg_addr == OFF_HEAD_AMP) ? {6'h00, head_amp_output_ctrl_q} :
        (reg_addr == OFF_P0_DIR)   ? p0_dir_q :
        (reg_addr == OFF_P0_LAT)   ? p0_lat_q :
        (reg_addr == OFF_P8_DIR)   ? p8_dir_q :
        (reg_addr == OFF_P8_LAT)   ? p8_gen_q :
        (reg_addr == OFF_P0_PINS)  ? p0_in :
        (reg_addr == OFF_P8_PINS)  ? p8_in :
        (reg_addr == OFF_P2_PINS)  ? {4'h0, p2_in} :
        (reg_addr == OFF_P7_PINS)  ? p7_in :
        (reg_addr == OFF_HEAD_LAT) ? {psv_run, 5'h00, head_lat_q} :
                                     8'h00;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    a_hi_nibble_load: assert property (
        @(posedge mclk) disable iff (!rst_b)
        rt_hi && !mode8 && timer0_cmp1_match
        |=> ##1 p0_out[7:4] == $past(nib_buf_q[7:4], 2))
        else $error("upper nibble not loaded on cmp1");
    a_wide_load: assert property (
        @(posedge mclk) disable iff (!rst_b)
        mode8 && rt_hi && rt_lo && trig_lo
        |=> ##1 p0_out == $past(nib_buf_q, 2))
        else $error("8-bit channel not loaded");
    a_ext_lo_load: assert property (
        @(posedge mclk) disable iff (!rst_b)
        rt_lo && nib_ctrl_q[NC_LO_EXT] && ext_irq0_event
        |=> p0_lat_q[3:0] == $past(nib_buf_q[3:0]))
        else $error("lower nibble not loaded on ext irq");
    a_buf_no_pin: assert property (
        @(posedge mclk) disable iff (!rst_b)
        wr_nbuf && !trig_hi && !trig_lo && !wr_p0lat
        |=> p0_lat_q == $past(p0_lat_q))
        else $error("buffer write changed port latch");
    a_head_amp_output_ctrl_direct: assert property (
        @(posedge mclk) disable iff (!rst_b)
        wr_head_amp_output_ctrl && rt2 && rt3 && !wr_vmode
        |=> ##1 p8_out[3:2] == $past(reg_wdata[1:0], 2))
        else $error("head-amp write not driven at once");
    a_cmp0_head: assert property (
        @(posedge mclk) disable iff (!rst_b)
        timer0_cmp0_match && !wr_head_amp_output_ctrl
        |=> head_lat_q == $past(head_amp_output_ctrl_q))
        else $error("head switch not updated at cmp0");
    a_hiz_release: assert property (
        @(posedge mclk) disable iff (!rst_b)
        rt0 && !psv_run && psv_lvl_q == LVL_HIZ |=> p8_oe_b[0])
        else $error("pseudo-sync bit driven while high impedance");
    a_hsync_super: assert property (
        @(posedge mclk) disable iff (!rst_b)
        rt0 && sup_on && hsync |=> !p8_out[0])
        else $error("hsync not superimposed");
    a_psv_start: assert property (
        @(posedge mclk) disable iff (!rst_b)
        rt0 && psv_on && bit0_trig && !wr_vmode
        |=> psv_run && psv_step_q == 3'h0)
        else $error("pattern did not start on trigger");
    a_pullup_input: assert property (
        @(posedge mclk) disable iff (!rst_b)
        ((p0_pu & ~p0_oe_b) == 8'h00) && ((p8_pu & ~p8_oe_b) == 8'h00))
        else $error("pull-up on a driven pin");
endmodule

// ===== dv/pin_load_model.sv
// load model of the circuits hanging on a port's pins
`timescale 1ns/1ps
module pin_load_model #(
    parameter int W = 8
) (
    // clock
    input  wire logic         mclk,
    // device side
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] oe_b,
    input  wire logic [W-1:0] pu,
    // external drivers
    input  wire logic [W-1:0] ext,
    input  wire logic [W-1:0] ext_en,
    // resolved pin level
    output logic      [W-1:0] pin
);
    logic [W-1:0] float_q = '0;

    // floating pins wander so a stale level never reads as good
    always @(posedge mclk) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!oe_b[i]) begin
                pin[i] = out[i];
            end else if (ext_en[i]) begin
                pin[i] = ext[i];
            end else if (pu[i]) begin
                pin[i] = 1'b1;
            end else begin
                pin[i] = float_q[i];
            end
        end
    end
endmodule

// ===== dv/tb_realtime_output_port.sv
// self-checking testbench for the real-time output port block
`timescale 1ns/1ps
module tb_realtime_output_port;
    import rtport_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic [15:0] tz_count = 16'h0000;
    logic        t1c3 = 1'b0;
    logic        t5c0 = 1'b0;
    logic        irq0 = 1'b0;
    logic        hsync = 1'b0;
    logic [15:0] cmp0_val = 16'h000a;
    logic [15:0] cmp1_val = 16'h0014;
    logic [15:0] cmp2_val = 16'h001e;
    logic [7:0]  p7_drv = 8'h96;
    logic [7:0]  p0_ext = 8'h00;
    logic [7:0]  p0_ext_en = 8'h00;
    logic [7:0]  p8_ext = 8'h00;
    logic [7:0]  p8_ext_en = 8'h02;
    logic [3:0]  p2_ext = 4'h1;
    logic [3:0]  p2_ext_en = 4'h3;
    logic [7:0]  p0_in, p0_out, p0_oe_b, p0_pu;
    logic [7:0]  p8_in, p8_out, p8_oe_b, p8_pu;
    logic [3:0]  p2_in, p2_pu;
    logic [7:0]  rdv;
    int          n_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #5 mclk = ~mclk;

    realtime_output_port u_realtime_output_port (
        .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .timer_zero_count(tz_count),
        .timer_zero_cmp0(cmp0_val), .timer_zero_cmp1(cmp1_val),
        .timer_zero_cmp2(cmp2_val), .timer1_cmp3_match(t1c3),
        .timer5_cmp0_match(t5c0), .ext_irq0_event(irq0), .hsync(hsync),
        .p0_in(p0_in), .p0_out(p0_out), .p0_oe_b(p0_oe_b), .p0_pu(p0_pu),
        .p8_in(p8_in), .p8_out(p8_out), .p8_oe_b(p8_oe_b), .p8_pu(p8_pu),
        .p2_in(p2_in), .p2_pu(p2_pu), .p7_in(p7_drv));
    pin_load_model u_pin_load_model_p0 (.mclk(mclk), .out(p0_out),
        .oe_b(p0_oe_b), .pu(p0_pu), .ext(p0_ext), .ext_en(p0_ext_en),
        .pin(p0_in));
    pin_load_model u_pin_load_model_p8 (.mclk(mclk), .out(p8_out),
        .oe_b(p8_oe_b), .pu(p8_pu), .ext(p8_ext), .ext_en(p8_ext_en),
        .pin(p8_in));
    pin_load_model #(.W(4)) u_pin_load_model_p2 (.mclk(mclk),
        .out(4'h0), .oe_b(4'hf), .pu(p2_pu), .ext(p2_ext),
        .ext_en(p2_ext_en), .pin(p2_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // 0 cmp1, 1 cmp2, 2 timer1 cmp3, 3 timer5 cmp0, 4 ext irq0, 5 cmp0
    task automatic fire(input int k);
        @(posedge mclk);
        case (k)
            0: tz_count <= cmp1_val;
            1: tz_count <= cmp2_val;
            2: t1c3 <= 1'b1;
            3: t5c0 <= 1'b1;
            4: irq0 <= 1'b1;
            default: tz_count <= cmp0_val;
        endcase
        @(posedge mclk);
        tz_count <= 16'h0000;
        t1c3 <= 1'b0;
        t5c0 <= 1'b0;
        irq0 <= 1'b0;
        idle(4);
    endtask
    task automatic edge_hsync(input logic v);
        @(posedge mclk);
        hsync <= v;
        idle(3);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(p0_out, 8'h00);
        chk(p0_pu, 8'hff);
        chk(p8_oe_b, 8'hff);
        chk({4'h0, p2_pu}, 8'h0c);
        rd(4'he, rdv);
        chk(rdv, 8'h00);
    endtask
    task automatic t_nibble();
        wr(OFF_NIB_BUF, 8'ha5);
        wr(OFF_NIB_CTRL, 8'h0e);
        idle(3);
        chk(p0_out, 8'h00);
        chk(p0_oe_b, 8'h00);
        fire(1);
        chk(p0_out, 8'h00);
        fire(4);
        chk(p0_out, 8'h05);
        fire(0);
        chk(p0_out, 8'ha5);
        wr(OFF_NIB_CTRL, 8'h0d);
        wr(OFF_NIB_BUF, 8'h3c);
        fire(1);
        chk(p0_out, 8'h3c);
    endtask
    task automatic t_dirs();
        wr(OFF_NIB_CTRL, 8'h00);
        wr(OFF_P0_DIR, 8'h0f);
        wr(OFF_P0_LAT, 8'h5a);
        idle(2);
        chk(p0_oe_b, 8'hf0);
        chk(p0_pu, 8'hf0);
        @(posedge mclk);
        p0_ext_en <= 8'h30;
        rd(OFF_P0_PINS, rdv);
        chk(rdv, 8'hca);
        rd(OFF_P2_PINS, rdv);
        chk(rdv, 8'h0d);
        rd(OFF_P7_PINS, rdv);
        chk(rdv, 8'h96);
    endtask
    task automatic t_bit0();
        logic lvl;
        for (int s = 0; s < 4; s++) begin
            lvl = (s % 2 == 0);
            wr(OFF_VID_MODE, 8'h01 | 8'(s << 4));
            wr(OFF_VID_BUF, {7'h00, lvl});
            for (int j = 0; j < 4; j++) begin
                if (j != s) begin
                    fire(j);
                    chk({7'h00, p8_out[0]}, {7'h00, ~lvl});
                end
            end
            fire(s);
            chk({6'h00, p8_oe_b[0], p8_out[0]}, {7'h00, lvl});
        end
        wr(OFF_VID_BUF, 8'h02);
        fire(3);
        chk({7'h00, p8_oe_b[0]}, 8'h01);
    endtask
    task automatic t_super();
        wr(OFF_VID_MODE, 8'h71);
        wr(OFF_VID_BUF, 8'h01);
        fire(3);
        edge_hsync(1'b1);
        chk({7'h00, p8_out[0]}, 8'h00);
        edge_hsync(1'b0);
        chk({7'h00, p8_out[0]}, 8'h01);
    endtask
    task automatic t_head();
        wr(OFF_VID_MODE, 8'h0c);
        wr(OFF_HEAD_AMP, 8'h03);
        idle(2);
        chk({4'h0, p8_oe_b[3:2], p8_out[3:2]}, 8'h03);
        chk(p8_pu, 8'hf3);
        rd(OFF_P8_PINS, rdv);
        chk(rdv, 8'hfd);
        fire(5);
        chk({6'h00, p8_out[3:2]}, 8'h03);
        wr(OFF_HEAD_AMP, 8'h01);
        idle(2);
        chk({6'h00, p8_out[3:2]}, 8'h01);
    endtask
    task automatic t_psv();
        wr(OFF_VID_MODE, 8'ha1);
        fire(2);
        chk({7'h00, p8_out[0]}, {7'h00, PSV_PATTERN[0]});
        rd(OFF_HEAD_LAT, rdv);
        chk(rdv, 8'h81);
        for (int i = 1; i < 12; i++) begin
            edge_hsync(1'b1);
            chk({7'h00, p8_out[0]}, 8'(PSV_PATTERN[i % 8]));
            edge_hsync(1'b0);
        end
        fire(2);
        chk({7'h00, p8_out[0]}, {7'h00, PSV_PATTERN[0]});
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("MISMATCH t=%0t run did not finish", $time);
            tally_and_finish();
        end
    end

    initial begin
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        idle(1);
        t_reset();
        t_nibble();
        t_dirs();
        t_bit0();
        t_super();
        t_head();
        t_psv();
        tally_and_finish();
    end
endmodule
